// ---- dv/otp_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.vh"
module otp_chk #(
    parameter [`OTP_CNT_W-1:0] TON_CYC = 32'h14,
    parameter [`OTP_CNT_W-1:0] SETTLE_CYC = 32'h8,
    parameter [`OTP_CNT_W-1:0] QUIET_CYC = 32'h5
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire sleep_select_n_i,
    input wire sample_vld_i,
    input wire [`OTP_ACC_W-1:0] accel_x_i,
    input wire [`OTP_ACC_W-1:0] accel_y_i,
    input wire [`OTP_ACC_W-1:0] accel_z_i,
    input wire tap_en_i,
    input wire dtap_en_i,
    input wire [`OTP_CNT_W-1:0] dtap_window_i,
    input wire portrait_flag_o,
    input wire landscape_flag_o,
    input wire polarity_flag_o,
    input wire data_valid_o,
    input wire tap_int_o,
    input wire double_tap_o,
    input wire chain_on_o
);
    reg [`OTP_CNT_W-1:0] still_ff;
    wire any_flag = portrait_flag_o | landscape_flag_o | polarity_flag_o;
    reg [`OTP_CNT_W-1:0] on_ff;
    // Cycles the chain has been on, saturating
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            on_ff <= 32'h0;
        end else if (!chain_on_o) begin
            on_ff <= 32'h0;
        end else if (~&on_ff) begin
            on_ff <= on_ff + 32'h1;
        end
    end
    // Cycles since the samples last moved, saturating
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            still_ff <= 32'h0;
        end else if ($changed({accel_x_i, accel_y_i, accel_z_i})) begin
            still_ff <= 32'h0;
        end else if (~&still_ff) begin
            still_ff <= still_ff + 32'h1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_pin_low;
        !sleep_select_n_i [*4];
    endsequence
    // Five, not four: the edge that releases reset takes no pin sample
    sequence s_pin_high;
        sleep_select_n_i [*5];
    endsequence
    sequence s_turn;
        data_valid_o && $past(data_valid_o)
            && ($changed(portrait_flag_o) || $changed(landscape_flag_o));
    endsequence
    property p_wake;
        s_pin_high |-> ##[1:2] chain_on_o;
    endproperty
    a_wake: assert property (p_wake) else $error("chain not on after wake");
    property p_sleep;
        s_pin_low |-> ##[1:2] !chain_on_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("chain on in sleep");
    property p_off;
        !chain_on_o [*2] |-> !(any_flag || data_valid_o || tap_int_o);
    endproperty
    a_off: assert property (p_off) else $error("output active in sleep");
    property p_one_axis;
        !(portrait_flag_o && landscape_flag_o);
    endproperty
    a_one_axis: assert property (p_one_axis) else $error("two axes flagged");
    property p_gated;
        any_flag |-> data_valid_o;
    endproperty
    a_gated: assert property (p_gated) else $error("flag before valid");
    property p_ton;
        data_valid_o |-> on_ff >= TON_CYC;
    endproperty
    a_ton: assert property (p_ton) else $error("valid before turn-on");
    property p_tap;
        tap_int_o |-> $past(sample_vld_i) && $past(tap_en_i) ##1 !tap_int_o [*3];
    endproperty
    a_tap: assert property (p_tap) else $error("tap pulse wrong");
    property p_dbl;
        double_tap_o |-> tap_int_o && $past(dtap_en_i);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double tap wrong");
    property p_settle;
        s_turn |-> still_ff >= SETTLE_CYC;
    endproperty
    a_settle: assert property (p_settle) else $error("flags moved early");
endmodule
bind otp_top otp_chk #(.TON_CYC(TON_CYC), .SETTLE_CYC(SETTLE_CYC), .QUIET_CYC(QUIET_CYC))
    otp_chk_inst (.*);
`default_nettype wire

// ---- dv/otp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module otp_host #(
    parameter [31:0] TON_CYC = 32'h14
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire wake_i,
    output wire sleep_select_n_o,
    output reg host_ok_o
);
    reg [31:0] wait_ff;
    assign sleep_select_n_o = wake_i;
    // Margin over turn-on for the pin synchroniser
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_ff <= 32'h0;
            host_ok_o <= 1'b0;
        end else if (!wake_i) begin
            wait_ff <= 32'h0;
            host_ok_o <= 1'b0;
        end else if (wait_ff < TON_CYC + 32'h8) begin
            wait_ff <= wait_ff + 32'h1;
        end else begin
            host_ok_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- dv/otp_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module otp_top_tb_top;
    localparam [31:0] TON = 32'h14;
    reg clk = 1'b0, rst_b = 1'b0, wake = 1'b1, tap_en = 1'b0, dtap_en = 1'b0;
    reg [11:0] ax = 12'h000, ay = 12'h000, az = 12'h000, v;
    reg [3:0] e;
    wire pin, ok, pf, lf, sf, dv, ti, dt, con;
    wire [3:0] fl = {pf, lf, sf, dv};
    integer bad_count = 0, cmp_count = 0, taps = 0, dbls = 0, i;
    otp_host #(.TON_CYC(TON)) otp_host_inst (.clk_i(clk), .rst_b_i(rst_b), .wake_i(wake),
        .sleep_select_n_o(pin), .host_ok_o(ok));
    otp_top #(.TON_CYC(TON), .SETTLE_CYC(32'h8), .QUIET_CYC(32'h5)) otp_top_inst (
        .clk_i(clk), .rst_b_i(rst_b), .ce_i(1'b1), .sleep_select_n_i(pin),
        .sample_vld_i(1'b1), .accel_x_i(ax), .accel_y_i(ay), .accel_z_i(az),
        .tap_en_i(tap_en), .dtap_en_i(dtap_en), .dtap_window_i(32'h28),
        .portrait_flag_o(pf), .landscape_flag_o(lf), .polarity_flag_o(sf),
        .data_valid_o(dv), .tap_int_o(ti), .double_tap_o(dt), .chain_on_o(con));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ti === 1'b1) taps = taps + 1;
        if (dt === 1'b1) dbls = dbls + 1;
    end
    // ****************
    // Access tasks
    // ****************
    task chk_f(input [63:0] nm, input [3:0] ex, input [3:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== ex) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s exp %h got %h", nm, ex, got);
            end
        end
    endtask
    task chk_n(input [63:0] nm, input integer ex, input integer got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== ex) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s exp %0d got %0d", nm, ex, got);
            end
        end
    endtask
    task put(input [11:0] x, input [11:0] y, input [11:0] z);
        begin
            @(posedge clk);
            ax <= x;
            ay <= y;
            az <= z;
        end
    endtask
    task hold(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // Jolt on x then back to face up; the return is blanked
    task jolt;
        begin
            put(12'h500, 12'h000, 12'h300);
            put(12'h000, 12'h000, 12'h300);
            hold(12);
        end
    endtask
    task give_verdict;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    initial begin
        #20000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    // ****************
    // Test sequence
    // ****************
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        hold(8);
        chk_f("chain", 4'h1, {3'h0, con});
        for (i = 0; i < 6; i = i + 1) begin
            v = i[0] ? 12'hD00 : 12'h300;
            put(i / 2 == 0 ? v : 12'h000, i / 2 == 1 ? v : 12'h000, i / 2 == 2 ? v : 12'h000);
            if (i > 0) begin
                hold(4);
                chk_f("settle", e, fl);
            end
            e = {i / 2 == 1, i / 2 == 0, !i[0], 1'b1};
            hold(40);
            chk_f("orient", e, fl);
        end
        put(12'h300, 12'h300, 12'h000);
        hold(30);
        chk_f("ambig", e, fl);
        put(12'h000, 12'h000, 12'h300);
        hold(30);
        @(posedge clk);
        tap_en <= 1'b1;
        dtap_en <= 1'b1;
        jolt;
        jolt;
        chk_n("taps", 2, taps);
        chk_n("dbl", 1, dbls);
        // Second tap after the window has closed stays single
        jolt;
        hold(40);
        jolt;
        hold(40);
        chk_n("taps", 4, taps);
        chk_n("dbl", 1, dbls);
        @(posedge clk);
        dtap_en <= 1'b0;
        jolt;
        jolt;
        @(posedge clk);
        tap_en <= 1'b0;
        jolt;
        chk_n("taps", 6, taps);
        chk_n("dbl", 1, dbls);
        @(posedge clk);
        wake <= 1'b0;
        tap_en <= 1'b1;
        hold(8);
        chk_f("sleep", 4'h0, fl);
        chk_f("chain", 4'h0, {3'h0, con});
        jolt;
        chk_n("taps", 6, taps);
        @(posedge clk);
        wake <= 1'b1;
        hold(12);
        chk_f("turnon", 4'h8, {con, dv, 2'h0});
        for (i = 0; i < 100 && ok !== 1'b1; i = i + 1) hold(1);
        hold(20);
        chk_f("resume", 4'h3, fl);
        give_verdict;
    end
endmodule
`default_nettype wire

// ---- rtl/otp_defines.vh ----
// Summary of operation
// - While held steady the block sorts its attitude against gravity into one of six orientations and shows it on the flag outputs.
// - The portrait flag is high while a portrait orientation is detected.
// - The landscape flag is high while a landscape orientation is detected.
// - The polarity flag tells the two opposite directions apart within the landscape, portrait or face group.
// - The host holds the active-low sleep select low for power-down and high for normal operation, and the block follows it.
// - In power-down the measurement chain is off and no orientation or tap detection takes place.
// - Valid outputs come a typical 30 ms after power-down is released, and the host ignores them until then.
// - With tap detection enabled a tap along any axis raises the dedicated tap interrupt line.
// - Optionally a second tap inside a programmable window after the first is reported as a double tap.
`ifndef OTP_DEFINES_VH
`define OTP_DEFINES_VH

// ******************************
// Clock and timing
// ******************************
`define OTP_CLK_MHZ 250
`define OTP_TON_MS 30
`define OTP_TON_CYC (`OTP_TON_MS * 1000 * `OTP_CLK_MHZ)
`define OTP_SETTLE_MS 50
`define OTP_SETTLE_CYC (`OTP_SETTLE_MS * 1000 * `OTP_CLK_MHZ)
`define OTP_QUIET_MS 20
`define OTP_QUIET_CYC (`OTP_QUIET_MS * 1000 * `OTP_CLK_MHZ)
`define OTP_CNT_W 32

// ******************************
// Sample format and thresholds
// ******************************
`define OTP_ACC_W 12
`define OTP_MAG_W 13
`define OTP_ORIENT_THR 13'h0200
`define OTP_TAP_THR 13'h0400

// ******************************
// Orientation codes
// ******************************
`define OTP_OR_NONE 3'h0
`define OTP_OR_LAND_POS 3'h1
`define OTP_OR_LAND_NEG 3'h2
`define OTP_OR_PORT_POS 3'h3
`define OTP_OR_PORT_NEG 3'h4
`define OTP_OR_FACE_POS 3'h5
`define OTP_OR_FACE_NEG 3'h6

`endif

// ---- rtl/otp_settle.v ----
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.vh"

module otp_settle (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire clr_i,
    input wire cand_vld_i,
    input wire [2:0] cand_i,
    input wire [`OTP_CNT_W-1:0] limit_i,
    output reg [2:0] code_o,
    output reg code_vld_o
);
    reg [2:0] pend_ff;
    reg [`OTP_CNT_W-1:0] cnt_ff;

    // Ambiguous samples hold the pending candidate, so tilting through
    // a diagonal does not restart the settling count.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_ff <= `OTP_OR_NONE;
            cnt_ff <= {`OTP_CNT_W{1'b0}};
            code_o <= `OTP_OR_NONE;
            code_vld_o <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                pend_ff <= `OTP_OR_NONE;
                cnt_ff <= {`OTP_CNT_W{1'b0}};
                code_o <= `OTP_OR_NONE;
                code_vld_o <= 1'b0;
            end else if (cand_vld_i && cand_i != `OTP_OR_NONE && cand_i != pend_ff) begin
                pend_ff <= cand_i;
                cnt_ff <= {`OTP_CNT_W{1'b0}};
            end else if (pend_ff != `OTP_OR_NONE) begin
                if (cnt_ff < limit_i) begin
                    cnt_ff <= cnt_ff + 1'b1;
                end else begin
                    code_o <= pend_ff;
                    code_vld_o <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/otp_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "otp_defines.vh"

module otp_top #(
    parameter [`OTP_CNT_W-1:0] TON_CYC = `OTP_TON_CYC,
    parameter [`OTP_CNT_W-1:0] SETTLE_CYC = `OTP_SETTLE_CYC,
    parameter [`OTP_CNT_W-1:0] QUIET_CYC = `OTP_QUIET_CYC
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire sleep_select_n_i,
    input wire sample_vld_i,
    input wire [`OTP_ACC_W-1:0] accel_x_i,
    input wire [`OTP_ACC_W-1:0] accel_y_i,
    input wire [`OTP_ACC_W-1:0] accel_z_i,
    input wire tap_en_i,
    input wire dtap_en_i,
    input wire [`OTP_CNT_W-1:0] dtap_window_i,
    output reg portrait_flag_o,
    output reg landscape_flag_o,
    output reg polarity_flag_o,
    output reg data_valid_o,
    output reg tap_int_o,
    output reg double_tap_o,
    output reg chain_on_o
);
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_BLANK = 2'b01;
    localparam [1:0] ST_ARMED = 2'b10;
    localparam [1:0] ST_BLANK2 = 2'b11;

    // ******************************
    // Sleep pin synchroniser
    // ******************************
    reg sync1_ff;
    reg sync2_ff;
    reg sync3_ff;
    reg awake_ff;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            awake_ff <= 1'b0;
        end else if (ce_i) begin
            sync1_ff <= sleep_select_n_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                awake_ff <= sync3_ff;
            end
        end
    end

    // ******************************
    // Turn-on delay
    // ******************************
    reg [`OTP_CNT_W-1:0] ton_cnt_ff;
    reg ready_ff;

    // Detection runs during turn-on; only the flag and data-valid outputs wait for it, not the tap outputs.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ton_cnt_ff <= {`OTP_CNT_W{1'b0}};
            ready_ff <= 1'b0;
        end else if (ce_i) begin
            if (!awake_ff) begin
                ton_cnt_ff <= {`OTP_CNT_W{1'b0}};
                ready_ff <= 1'b0;
            end else if (ton_cnt_ff < TON_CYC - 1'b1) begin
                ton_cnt_ff <= ton_cnt_ff + 1'b1;
            end else begin
                ready_ff <= 1'b1;
            end
        end
    end

    // ******************************
    // Per-axis magnitude and jolt
    // ******************************
    wire [3*`OTP_ACC_W-1:0] acc_bus;
    wire [3*`OTP_MAG_W-1:0] mag_bus;
    wire [2:0] neg_bus;
    wire [2:0] jolt_bus;
    reg [3*`OTP_ACC_W-1:0] prev_ff;
    reg prev_vld_ff;

    assign acc_bus = {accel_z_i, accel_y_i, accel_x_i};

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
            wire signed [`OTP_MAG_W-1:0] cur;
            wire signed [`OTP_MAG_W-1:0] old;
            wire signed [`OTP_MAG_W-1:0] dif;
            assign cur = {acc_bus[(ax+1)*`OTP_ACC_W-1], acc_bus[ax*`OTP_ACC_W +: `OTP_ACC_W]};
            assign old = {prev_ff[(ax+1)*`OTP_ACC_W-1], prev_ff[ax*`OTP_ACC_W +: `OTP_ACC_W]};
            assign dif = cur - old;
            assign neg_bus[ax] = cur[`OTP_MAG_W-1];
            assign mag_bus[ax*`OTP_MAG_W +: `OTP_MAG_W] = cur[`OTP_MAG_W-1] ? -cur : cur;
            assign jolt_bus[ax] = (dif[`OTP_MAG_W-1] ? -dif : dif) > `OTP_TAP_THR;
        end
    endgenerate

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_ff <= {3*`OTP_ACC_W{1'b0}};
            prev_vld_ff <= 1'b0;
        end else if (ce_i) begin
            if (!awake_ff) begin
                prev_vld_ff <= 1'b0;
            end else if (sample_vld_i) begin
                prev_ff <= acc_bus;
                prev_vld_ff <= 1'b1;
            end
        end
    end

    // ******************************
    // Orientation classification
    // ******************************
    wire [`OTP_MAG_W-1:0] mag_x = mag_bus[0*`OTP_MAG_W +: `OTP_MAG_W];
    wire [`OTP_MAG_W-1:0] mag_y = mag_bus[1*`OTP_MAG_W +: `OTP_MAG_W];
    wire [`OTP_MAG_W-1:0] mag_z = mag_bus[2*`OTP_MAG_W +: `OTP_MAG_W];
    reg [2:0] cand;

    // Strict dominance: a tie between axes is a diagonal and gives no vote.
    always @* begin
        cand = `OTP_OR_NONE;
        if (mag_x > mag_y && mag_x > mag_z && mag_x > `OTP_ORIENT_THR) begin
            cand = neg_bus[0] ? `OTP_OR_LAND_NEG : `OTP_OR_LAND_POS;
        end else if (mag_y > mag_x && mag_y > mag_z && mag_y > `OTP_ORIENT_THR) begin
            cand = neg_bus[1] ? `OTP_OR_PORT_NEG : `OTP_OR_PORT_POS;
        end else if (mag_z > mag_x && mag_z > mag_y && mag_z > `OTP_ORIENT_THR) begin
            cand = neg_bus[2] ? `OTP_OR_FACE_NEG : `OTP_OR_FACE_POS;
        end
    end

    wire [2:0] stable_code;
    wire stable_vld;

    otp_settle otp_settle_inst (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .clr_i(!awake_ff),
        .cand_vld_i(sample_vld_i),
        .cand_i(cand),
        .limit_i(SETTLE_CYC),
        .code_o(stable_code),
        .code_vld_o(stable_vld)
    );

    // ******************************
    // Flag outputs
    // ******************************
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            portrait_flag_o <= 1'b0;
            landscape_flag_o <= 1'b0;
            polarity_flag_o <= 1'b0;
            data_valid_o <= 1'b0;
            chain_on_o <= 1'b0;
        end else if (ce_i) begin
            chain_on_o <= awake_ff;
            data_valid_o <= ready_ff && stable_vld;
            portrait_flag_o <= 1'b0;
            landscape_flag_o <= 1'b0;
            polarity_flag_o <= 1'b0;
            if (ready_ff && stable_vld) begin
                case (stable_code)
                    `OTP_OR_LAND_POS: begin
                        landscape_flag_o <= 1'b1;
                        polarity_flag_o <= 1'b1;
                    end
                    `OTP_OR_LAND_NEG: begin
                        landscape_flag_o <= 1'b1;
                    end
                    `OTP_OR_PORT_POS: begin
                        portrait_flag_o <= 1'b1;
                        polarity_flag_o <= 1'b1;
                    end
                    `OTP_OR_PORT_NEG: begin
                        portrait_flag_o <= 1'b1;
                    end
                    `OTP_OR_FACE_POS: begin
                        polarity_flag_o <= 1'b1;
                    end
                    default: begin
                        polarity_flag_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ******************************
    // Tap and double-tap detection
    // ******************************
    reg [1:0] tap_st_ff;
    reg [`OTP_CNT_W-1:0] tap_cnt_ff;
    wire hit = tap_en_i && awake_ff && sample_vld_i && prev_vld_ff && (|jolt_bus);

    // Window is counted from the first tap, blanking included.
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tap_st_ff <= ST_IDLE;
            tap_cnt_ff <= {`OTP_CNT_W{1'b0}};
            tap_int_o <= 1'b0;
            double_tap_o <= 1'b0;
        end else if (ce_i) begin
            tap_int_o <= 1'b0;
            double_tap_o <= 1'b0;
            if (!awake_ff || !tap_en_i) begin
                tap_st_ff <= ST_IDLE;
                tap_cnt_ff <= {`OTP_CNT_W{1'b0}};
            end else begin
                tap_cnt_ff <= tap_cnt_ff + 1'b1;
                case (tap_st_ff)
                    ST_IDLE: begin
                        tap_cnt_ff <= {`OTP_CNT_W{1'b0}};
                        if (hit) begin
                            tap_int_o <= 1'b1;
                            tap_st_ff <= ST_BLANK;
                        end
                    end
                    ST_BLANK: begin
                        if (tap_cnt_ff >= QUIET_CYC - 1'b1) begin
                            tap_st_ff <= dtap_en_i ? ST_ARMED : ST_IDLE;
                        end
                    end
                    ST_ARMED: begin
                        if (tap_cnt_ff >= dtap_window_i) begin
                            tap_st_ff <= ST_IDLE;
                        end else if (hit) begin
                            tap_int_o <= 1'b1;
                            double_tap_o <= 1'b1;
                            tap_cnt_ff <= {`OTP_CNT_W{1'b0}};
                            tap_st_ff <= ST_BLANK2;
                        end
                    end
                    ST_BLANK2: begin
                        if (tap_cnt_ff >= QUIET_CYC - 1'b1) begin
                            tap_st_ff <= ST_IDLE;
                        end
                    end
                    default: begin
                        tap_st_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire
